// ===== hdl/pcg_pkg.sv
// Purpose: shared constants and types for the loop clock generator core
// Assumes: one clock domain, clock ticks arrive as one-cycle enables
// Notes:   register indexes are word indexes; byte address is four times the index
package pcg_pkg;

  // register word indexes and byte addresses
  localparam logic [7:0]  IDX_LOOP_CTRL  = 8'h3A;  // loop_control_reg
  localparam logic [7:0]  IDX_BANDWIDTH  = 8'h3B;  // bandwidth_control_reg
  localparam logic [7:0]  IDX_MULT_HIGH  = 8'h3C;  // multiplier_high_reg
  localparam logic [7:0]  IDX_MULT_LOW   = 8'h3D;  // multiplier_low_reg
  localparam logic [7:0]  IDX_REF_DIV    = 8'h3E;  // reference_divider_reg
  localparam int          ADDR_W         = 12;     // byte address width
  localparam logic [11:0] ADDR_LOOP_CTRL = {2'b00, IDX_LOOP_CTRL, 2'b00};
  localparam logic [11:0] ADDR_BANDWIDTH = {2'b00, IDX_BANDWIDTH, 2'b00};
  localparam logic [11:0] ADDR_MULT_HIGH = {2'b00, IDX_MULT_HIGH, 2'b00};
  localparam logic [11:0] ADDR_MULT_LOW  = {2'b00, IDX_MULT_LOW, 2'b00};
  localparam logic [11:0] ADDR_REF_DIV   = {2'b00, IDX_REF_DIV, 2'b00};

  // loop_control_reg fields
  localparam int BIT_IRQ_EN   = 7;  // lock_change_irq_enable
  localparam int BIT_IRQ_FLAG = 6;  // lock change flag
  localparam int BIT_LOOP_ON  = 5;  // loop enable
  localparam int BIT_BASE_SEL = 4;  // base_source_select
  localparam int BIT_PRE_HI   = 3;  // prescale exponent msb
  localparam int BIT_PRE_LO   = 2;  // prescale exponent lsb
  // bandwidth_control_reg fields
  localparam int BIT_AUTO     = 7;  // automatic bandwidth select
  localparam int BIT_LOCK     = 6;  // lock status
  localparam int BIT_TRACK    = 5;  // tracking_mode_flag

  // reset values
  localparam logic [7:0]  RST_LOOP_CTRL = 8'h28;   // loop on, prescale field 2'b10
  localparam logic [7:0]  RST_BANDWIDTH = 8'h00;
  localparam logic [11:0] RST_MULT      = 12'h000;
  localparam logic [7:0]  RST_REF_DIV   = 8'h00;

  // field widths
  localparam int MULT_W   = 12;
  localparam int MULT_H_W = 4;
  localparam int PRE_W    = 2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // lock detector timing and tolerances, counted in feedback ticks per window
  localparam int          LOCK_WIN    = 16;  // reference ticks per decision window
  localparam logic [7:0]  TOL_TRACK   = 8'h01;
  localparam logic [7:0]  TOL_UNTRACK = 8'h03;
  localparam logic [7:0]  TOL_LOCK    = 8'h00;
  localparam logic [7:0]  TOL_UNLOCK  = 8'h02;

  // base clock source change: cycles of each source held static
  localparam logic [1:0] SWITCH_HOLD = 2'h3;

  typedef enum logic {SEL_RUN, SEL_HOLD} pcg_sel_state_t;

endpackage

// ===== hdl/pcg_mod_div.sv
// Purpose: modulo divider of a tick stream
// Assumes: tick_in is a one-cycle enable in the aclk domain
// Notes:   a factor of zero divides by one
`timescale 1ns/1ps
`default_nettype none
module pcg_mod_div #(
  parameter int W = 8                      // factor width
) (
  input  wire logic         aclk,          // core clock
  input  wire logic         aresetn,       // sync reset, active low
  input  wire logic         ce,            // clock enable
  input  wire logic         clr,           // restart count
  input  wire logic         tick_in,       // input tick
  input  wire logic [W-1:0] factor,        // division factor
  output logic              tick_out       // divided tick, registered
);
  logic [W-1:0] cnt_reg;                   // ticks seen in current period
  logic [W-1:0] eff_factor;                // factor with zero mapped to one

  // zero behaves like one
  assign eff_factor = (factor == '0) ? W'(1) : factor;

  // count input ticks and emit one output tick per factor
  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && clr)) begin
      cnt_reg  <= '0;
      tick_out <= 1'b0;
    end else if (ce) begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (cnt_reg >= eff_factor - W'(1)) begin
          cnt_reg  <= '0;
          tick_out <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + W'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== hdl/pcg_core.sv
// Purpose: digital core of a loop clock generator with AXI4-Lite registers
// Assumes: crystal and oscillator edges arrive as one-cycle ticks synchronous to aclk
// Notes:   analog filter is outside; correction outputs drive it
`timescale 1ns/1ps
`default_nettype none
// Operation
// - crystal clock runs only while enabled
// - crystal clock buffered into loop reference
// - base clock is crystal or loop, halved
// - reference divided by R
// - oscillator divided by 2^P then N
// - phase comparator emits directional correction pulses
// - lock detector compares feedback and reference frequency
// - acquisition shown by clear tracking flag
// - tracking whenever flag set
// - mode switching automatic or manual
// - auto select lets detector switch modes
// - auto tracking flag read-only with hysteresis
// - auto lock bit read-only with hysteresis
// - lock change raises interrupt when enabled
// - zero R or N acts as one
// - hold output three cycles each clock
// - loop on and selection interlocked
module pcg_core #(
  parameter int R_W = 8                       // reference divider width
) (
  input  wire logic        aclk,              // core clock, 200 MHz
  input  wire logic        aresetn,           // sync reset, active low
  input  wire logic        ce,                // clock enable, freezes state when low
  input  wire logic        oscillator_enable_in, // oscillator enable from integration unit
  input  wire logic        crystal_tick_in,   // crystal amplifier edge tick
  input  wire logic        vco_tick_in,       // oscillator edge tick
  output logic             crystal_clock,     // gated crystal tick
  output logic             loop_reference_clock, // buffered reference tick
  output logic             divided_reference_clock, // reference over R tick
  output logic             feedback_clock,    // feedback tick
  output logic             loop_output_clock, // oscillator output tick
  output logic             base_clock_out,    // halved selected clock level
  output logic             correction_up,     // speed-up correction pulse
  output logic             correction_down,   // slow-down correction pulse
  output logic             lock_change_irq,   // interrupt request level
  input  wire logic [11:0] s_axi_awaddr,      // write address
  input  wire logic        s_axi_awvalid,     // write address valid
  output logic             s_axi_awready,     // write address ready
  input  wire logic [31:0] s_axi_wdata,       // write data
  input  wire logic [3:0]  s_axi_wstrb,       // write strobes
  input  wire logic        s_axi_wvalid,      // write data valid
  output logic             s_axi_wready,      // write data ready
  output logic [1:0]       s_axi_bresp,       // write response
  output logic             s_axi_bvalid,      // write response valid
  input  wire logic        s_axi_bready,      // write response ready
  input  wire logic [11:0] s_axi_araddr,      // read address
  input  wire logic        s_axi_arvalid,     // read address valid
  output logic             s_axi_arready,     // read address ready
  output logic [31:0]      s_axi_rdata,       // read data
  output logic [1:0]       s_axi_rresp,       // read response
  output logic             s_axi_rvalid,      // read valid
  input  wire logic        s_axi_rready       // read ready
);
  // ---------------- registers ----------------
  logic                            irq_en_reg;     // lock change interrupt enable
  logic                            irq_flag_reg;   // sticky lock change flag
  logic                            loop_on_reg;    // loop enable
  logic                            base_sel_reg;   // requested base source
  logic [pcg_pkg::PRE_W-1:0]       pre_reg;        // prescale exponent
  logic                            auto_reg;       // automatic bandwidth select
  logic                            track_reg;      // tracking_mode_flag
  logic                            lock_reg;       // lock status
  logic [pcg_pkg::MULT_W-1:0]      mult_reg;       // multiplier N
  logic [R_W-1:0]                  rdiv_reg;       // reference divider R

  // bus state
  logic                    aw_held_reg;   // write address captured
  logic                    w_held_reg;    // write data captured
  logic [11:0]             waddr_reg;     // captured write address
  logic [7:0]              wbyte_reg;     // captured low byte
  logic                    wlane_reg;     // low byte lane was strobed
  logic                    wr_fire;       // both halves present, apply write
  logic                    rd_fire;       // read address taken
  logic                    rd_ctrl;       // read of control register, clears flag
  logic [7:0]              rd_byte;       // decoded read value
  logic                    rd_hit;        // read address mapped

  // loop datapath
  logic                    osc_run;        // oscillator running
  logic                    vco_tick;       // gated oscillator tick
  logic [2:0]              presc_cnt_reg;  // prescale counter
  logic [2:0]              presc_mask;     // low P bits mask
  logic                    presc_tick_reg; // prescaled tick
  logic [7:0]              win_cnt_reg;    // reference ticks in window
  logic [7:0]              fb_cnt_reg;     // feedback ticks in window
  logic [7:0]              freq_err;       // absolute count error
  logic                    win_end;        // window complete this cycle
  logic                    lock_next;      // lock value from detector

  // base selector
  pcg_pkg::pcg_sel_state_t sel_state_reg;  // selector state
  logic                    sel_active_reg; // source now driving output
  logic [1:0]              hold_x_reg;     // crystal ticks held
  logic [1:0]              hold_l_reg;     // loop ticks held
  logic                    src_tick;       // tick of the active source

  // ---------------- clock datapath ----------------
  assign osc_run  = oscillator_enable_in;
  assign vco_tick = vco_tick_in && osc_run && loop_on_reg;

  // crystal only runs while enabled; buffered copy feeds the loop; loop output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crystal_clock        <= 1'b0;
      loop_reference_clock <= 1'b0;
      loop_output_clock    <= 1'b0;
    end else if (ce) begin
      crystal_clock        <= crystal_tick_in && osc_run;
      loop_reference_clock <= crystal_tick_in && osc_run;
      loop_output_clock    <= vco_tick;
    end
  end

  // reference divided by R
  pcg_mod_div #(.W(R_W)) u_ref_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .clr      (!loop_on_reg),
    .tick_in  (loop_reference_clock),
    .factor   (rdiv_reg),
    .tick_out (divided_reference_clock)
  );

  // power of two prescale; a tick leaves when the low P bits roll over
  assign presc_mask = 3'((4'b0001 << pre_reg) - 4'b0001);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_cnt_reg  <= '0;
      presc_tick_reg <= 1'b0;
    end else if (ce) begin
      presc_tick_reg <= vco_tick && ((presc_cnt_reg & presc_mask) == presc_mask);
      if (vco_tick) begin
        presc_cnt_reg <= presc_cnt_reg + 3'h1;
      end
    end
  end

  // modulo N after the prescaler
  pcg_mod_div #(.W(pcg_pkg::MULT_W)) u_fb_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .clr      (!loop_on_reg),
    .tick_in  (presc_tick_reg),
    .factor   (mult_reg),
    .tick_out (feedback_clock)
  );

  // three-state phase comparator; coincident edges cancel
  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && !loop_on_reg)) begin
      correction_up   <= 1'b0;
      correction_down <= 1'b0;
    end else if (ce) begin
      if (divided_reference_clock && feedback_clock) begin
        correction_up   <= 1'b0;
        correction_down <= 1'b0;
      end else if (divided_reference_clock) begin
        correction_up   <= !correction_down;
        correction_down <= 1'b0;
      end else if (feedback_clock) begin
        correction_down <= !correction_up;
        correction_up   <= 1'b0;
      end
    end
  end

  // ---------------- lock detector ----------------
  // frequency compare over a window of reference ticks, so it runs at the reference rate
  assign win_end  = divided_reference_clock && (win_cnt_reg == 8'(pcg_pkg::LOCK_WIN - 1));
  assign freq_err = (fb_cnt_reg > 8'(pcg_pkg::LOCK_WIN))
                  ? fb_cnt_reg - 8'(pcg_pkg::LOCK_WIN)
                  : 8'(pcg_pkg::LOCK_WIN) - fb_cnt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && !loop_on_reg)) begin
      win_cnt_reg <= '0;
      fb_cnt_reg  <= '0;
    end else if (ce) begin
      if (win_end) begin
        win_cnt_reg <= '0;
        fb_cnt_reg  <= 8'(feedback_clock);
      end else begin
        if (divided_reference_clock) begin
          win_cnt_reg <= win_cnt_reg + 8'h01;
        end
        if (feedback_clock && fb_cnt_reg != 8'hFF) begin
          fb_cnt_reg <= fb_cnt_reg + 8'h01;
        end
      end
    end
  end

  // lock with hysteresis; forced clear while the loop is off
  always_comb begin
    lock_next = lock_reg;
    if (!loop_on_reg) begin
      lock_next = 1'b0;
    end else if (win_end && freq_err <= pcg_pkg::TOL_LOCK) begin
      lock_next = 1'b1;
    end else if (win_end && freq_err > pcg_pkg::TOL_UNLOCK) begin
      lock_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_reg <= 1'b0;
    end else if (ce) begin
      lock_reg <= lock_next;
    end
  end

  // tracking flag: detector drives it in auto, software in manual; clear means acquisition
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      track_reg <= 1'b0;
    end else if (ce) begin
      if (!loop_on_reg) begin
        track_reg <= 1'b0;
      end else if (auto_reg) begin
        if (win_end && freq_err <= pcg_pkg::TOL_TRACK) begin
          track_reg <= 1'b1;
        end else if (win_end && freq_err > pcg_pkg::TOL_UNTRACK) begin
          track_reg <= 1'b0;
        end
      end else if (wr_fire && wlane_reg && waddr_reg == pcg_pkg::ADDR_BANDWIDTH) begin
        track_reg <= wbyte_reg[pcg_pkg::BIT_TRACK];
      end
    end
  end
  // filter mode has no port of its own; software reads it as track_reg: set means small corrections

  // ---------------- base clock selector ----------------
  assign src_tick = sel_active_reg ? loop_output_clock : crystal_clock;

  // on a source change hold output static for three ticks of each source, then switch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_state_reg  <= pcg_pkg::SEL_RUN;
      sel_active_reg <= 1'b0;
      hold_x_reg     <= '0;
      hold_l_reg     <= '0;
      base_clock_out <= 1'b0;
    end else if (ce) begin
      case (sel_state_reg)
        pcg_pkg::SEL_RUN: begin
          if (src_tick) begin
            base_clock_out <= !base_clock_out;
          end
          if (base_sel_reg != sel_active_reg) begin
            sel_state_reg <= pcg_pkg::SEL_HOLD;
            hold_x_reg    <= '0;
            hold_l_reg    <= '0;
          end
        end
        pcg_pkg::SEL_HOLD: begin
          if (crystal_clock && hold_x_reg != pcg_pkg::SWITCH_HOLD) begin
            hold_x_reg <= hold_x_reg + 2'h1;
          end
          if (loop_output_clock && hold_l_reg != pcg_pkg::SWITCH_HOLD) begin
            hold_l_reg <= hold_l_reg + 2'h1;
          end
          if (hold_x_reg == pcg_pkg::SWITCH_HOLD && hold_l_reg == pcg_pkg::SWITCH_HOLD) begin
            sel_active_reg <= base_sel_reg;
            sel_state_reg  <= pcg_pkg::SEL_RUN;
          end
        end
        default: sel_state_reg <= pcg_pkg::SEL_RUN;
      endcase
    end
  end

  // ---------------- AXI4-Lite slave ----------------
  // readies fall with ce, so a frozen core never takes a request it cannot store
  assign s_axi_awready = ce && !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = ce && !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  // capture address and data in either order, answer once both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      waddr_reg    <= '0;
      wbyte_reg    <= '0;
      wlane_reg    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pcg_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        waddr_reg   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wbyte_reg  <= s_axi_wdata[7:0];
        wlane_reg  <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (waddr_reg == pcg_pkg::ADDR_LOOP_CTRL || waddr_reg == pcg_pkg::ADDR_BANDWIDTH ||
            waddr_reg == pcg_pkg::ADDR_MULT_HIGH || waddr_reg == pcg_pkg::ADDR_MULT_LOW ||
            waddr_reg == pcg_pkg::ADDR_REF_DIV) begin
          s_axi_bresp <= pcg_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= pcg_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // software writable fields; only the low byte lane carries register data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_reg   <= pcg_pkg::RST_LOOP_CTRL[pcg_pkg::BIT_IRQ_EN];
      loop_on_reg  <= pcg_pkg::RST_LOOP_CTRL[pcg_pkg::BIT_LOOP_ON];
      base_sel_reg <= pcg_pkg::RST_LOOP_CTRL[pcg_pkg::BIT_BASE_SEL];
      pre_reg      <= pcg_pkg::RST_LOOP_CTRL[pcg_pkg::BIT_PRE_HI:pcg_pkg::BIT_PRE_LO];
      auto_reg     <= pcg_pkg::RST_BANDWIDTH[pcg_pkg::BIT_AUTO];
      mult_reg     <= pcg_pkg::RST_MULT;
      rdiv_reg     <= R_W'(pcg_pkg::RST_REF_DIV);
    end else if (ce && wr_fire && wlane_reg) begin
      if (waddr_reg == pcg_pkg::ADDR_LOOP_CTRL) begin
        irq_en_reg <= wbyte_reg[pcg_pkg::BIT_IRQ_EN];
        pre_reg    <= wbyte_reg[pcg_pkg::BIT_PRE_HI:pcg_pkg::BIT_PRE_LO];
        // loop on/off and selection may not change together; loop stays on while selected
        if (wbyte_reg[pcg_pkg::BIT_LOOP_ON] == loop_on_reg) begin
          if (!wbyte_reg[pcg_pkg::BIT_BASE_SEL] || loop_on_reg) begin
            base_sel_reg <= wbyte_reg[pcg_pkg::BIT_BASE_SEL];
          end
        end else if (wbyte_reg[pcg_pkg::BIT_BASE_SEL] == base_sel_reg) begin
          if (wbyte_reg[pcg_pkg::BIT_LOOP_ON] || (!base_sel_reg && !sel_active_reg)) begin
            loop_on_reg <= wbyte_reg[pcg_pkg::BIT_LOOP_ON];
          end
        end
      end else if (waddr_reg == pcg_pkg::ADDR_BANDWIDTH) begin
        auto_reg <= wbyte_reg[pcg_pkg::BIT_AUTO];
      end else if (waddr_reg == pcg_pkg::ADDR_MULT_HIGH) begin
        mult_reg[pcg_pkg::MULT_W-1:8] <= wbyte_reg[pcg_pkg::MULT_H_W-1:0];
      end else if (waddr_reg == pcg_pkg::ADDR_MULT_LOW) begin
        mult_reg[7:0] <= wbyte_reg;
      end else if (waddr_reg == pcg_pkg::ADDR_REF_DIV) begin
        rdiv_reg <= wbyte_reg[R_W-1:0];
      end
    end
  end

  // sticky lock change flag; a change in the clearing cycle wins over the clear
  assign rd_ctrl = rd_fire && s_axi_araddr == pcg_pkg::ADDR_LOOP_CTRL;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_flag_reg <= 1'b0;
    end else if (ce) begin
      if (lock_next != lock_reg) begin
        irq_flag_reg <= 1'b1;
      end else if (rd_ctrl) begin
        irq_flag_reg <= 1'b0;
      end
    end
  end
  assign lock_change_irq = irq_flag_reg && irq_en_reg;

  // read decode
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    if (s_axi_araddr == pcg_pkg::ADDR_LOOP_CTRL) begin
      rd_byte[pcg_pkg::BIT_IRQ_EN]   = irq_en_reg;
      rd_byte[pcg_pkg::BIT_IRQ_FLAG] = irq_flag_reg;
      rd_byte[pcg_pkg::BIT_LOOP_ON]  = loop_on_reg;
      rd_byte[pcg_pkg::BIT_BASE_SEL] = base_sel_reg;
      rd_byte[pcg_pkg::BIT_PRE_HI:pcg_pkg::BIT_PRE_LO] = pre_reg;
    end else if (s_axi_araddr == pcg_pkg::ADDR_BANDWIDTH) begin
      rd_byte[pcg_pkg::BIT_AUTO]  = auto_reg;
      rd_byte[pcg_pkg::BIT_LOCK]  = lock_reg;
      rd_byte[pcg_pkg::BIT_TRACK] = track_reg;
    end else if (s_axi_araddr == pcg_pkg::ADDR_MULT_HIGH) begin
      rd_byte[pcg_pkg::MULT_H_W-1:0] = mult_reg[pcg_pkg::MULT_W-1:8];
    end else if (s_axi_araddr == pcg_pkg::ADDR_MULT_LOW) begin
      rd_byte = mult_reg[7:0];
    end else if (s_axi_araddr == pcg_pkg::ADDR_REF_DIV) begin
      rd_byte[R_W-1:0] = rdiv_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // read data registered; held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= pcg_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= rd_hit ? pcg_pkg::RESP_OKAY : pcg_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/pcg_checker.sv
// Purpose: port checker for the loop clock generator core
// Assumes: ce is high while the checks matter
// Notes:   bound to every instance of the core
`timescale 1ns/1ps
`default_nettype none
module pcg_checker (
  input wire logic aclk, aresetn, ce, oscillator_enable_in, crystal_tick_in, vco_tick_in,
  input wire logic crystal_clock, loop_reference_clock, loop_output_clock,
  input wire logic divided_reference_clock, feedback_clock, correction_up, correction_down,
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_bvalid, s_axi_bready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  xtal_gate_a:
    assert property (ce && crystal_tick_in && oscillator_enable_in |=> crystal_clock) else $error("crystal tick lost");
  xtal_stop_a:
    assert property (ce && !oscillator_enable_in |=> !crystal_clock && !loop_output_clock) else $error("tick while disabled");
  ref_buffer_a:
    assert property (loop_reference_clock == crystal_clock) else $error("reference differs");
  loop_tick_a:
    assert property (loop_output_clock |-> $past(vco_tick_in && oscillator_enable_in)) else $error("loop tick uncaused");
  fb_origin_a:
    assert property (feedback_clock |-> $past(loop_output_clock)) else $error("feedback tick uncaused");
  corr_excl_a:
    assert property (!(correction_up && correction_down)) else $error("both corrections");
  corr_cause_a:
    assert property ($rose(correction_up) |-> divided_reference_clock || $past(divided_reference_clock) || $past(divided_reference_clock, 2)) else $error("up without reference");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  write_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write response dropped");
  cover property (correction_up);
  cover property ($rose(loop_output_clock));
  cover property (s_axi_rvalid);
endmodule
bind pcg_core pcg_checker u_chk (.*);
`default_nettype wire

// ===== tb/pcg_osc_model.sv
// Purpose: crystal, oscillator and enable source beside the core
// Assumes: ticks are one-cycle pulses in the aclk domain
// Notes:   oscillator period divides the crystal period, so its rate is a whole multiple
`timescale 1ns/1ps
`default_nettype none
module pcg_osc_model #(parameter int XP = 8, parameter int VP = 2) (
  input  wire logic aclk,                         // core clock
  input  wire logic run,                          // bench asks the unit to run
  output logic      oscillator_enable_in = 1'b0,  // enable to the core
  output logic      crystal_tick_in = 1'b0,       // crystal edges, still when stopped
  output logic      vco_tick_in = 1'b0            // oscillator edges
);
  int cnt = 0;  // free phase counter
  // ticks stop with the enable, as a real stopped oscillator would
  always_ff @(posedge aclk) begin
    cnt <= cnt + 1;
    oscillator_enable_in <= run;
    crystal_tick_in <= run && (cnt % XP == 0);
    vco_tick_in <= run && (cnt % VP == 0);
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: register-level test of the loop clock generator core
// Assumes: crystal tick every 8 cycles, oscillator every 2, so N=4 locks
// Notes:   ce stays high
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic aclk, aresetn, ce, run, b, oscillator_enable_in, crystal_tick_in, vco_tick_in;
  logic crystal_clock, loop_reference_clock, divided_reference_clock, feedback_clock;
  logic loop_output_clock, base_clock_out, correction_up, correction_down, lock_change_irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int miscompares = 0, tests_run = 0, n;
  pcg_core u_dut (.*);
  pcg_osc_model u_osc (.*);
  initial begin
    aclk = 0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // write: both halves offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0000_00, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 0;
    if (i == 50) begin miscompares++; results(); end
  endtask
  task automatic rd(input logic [11:0] a);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 0;
    if (i == 50) begin miscompares++; results(); end
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    {ce, run, s_axi_wstrb} = 6'h3F;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    rd(pcg_pkg::ADDR_LOOP_CTRL); chk("control reset", rd_d, 32'h0000_0028);
    rd(pcg_pkg::ADDR_BANDWIDTH); chk("bandwidth reset", rd_d, 32'h0000_0000);
    rd(12'h004); chk("unmapped resp", rd_r, pcg_pkg::RESP_SLVERR);
    wr(pcg_pkg::ADDR_MULT_LOW, 8'h04); wr(pcg_pkg::ADDR_REF_DIV, 8'h01);
    wr(pcg_pkg::ADDR_LOOP_CTRL, 8'hA0); wr(pcg_pkg::ADDR_BANDWIDTH, 8'h80);
    for (n = 0; n < 400 && rd_d[6] !== 1'b1; n++) rd(pcg_pkg::ADDR_BANDWIDTH);
    chk("lock irq", lock_change_irq, 1);
    wr(pcg_pkg::ADDR_BANDWIDTH, 8'h80); rd(pcg_pkg::ADDR_BANDWIDTH);
    chk("auto lock track", rd_d[7:5], 3'b111);
    rd(pcg_pkg::ADDR_LOOP_CTRL); chk("lock flag", rd_d[6], 1);
    wr(pcg_pkg::ADDR_LOOP_CTRL, 8'h30); wr(pcg_pkg::ADDR_LOOP_CTRL, 8'h10);
    rd(pcg_pkg::ADDR_LOOP_CTRL); chk("interlock", rd_d[5:4], 2'b11);
    rd(pcg_pkg::ADDR_BANDWIDTH); chk("lock on loop", rd_d[6], 1);
    n = 0;
    repeat (80) begin b = base_clock_out; @(posedge aclk); n += int'(b !== base_clock_out); end
    chk("loop base rate", n > 20, 1);
    wr(pcg_pkg::ADDR_LOOP_CTRL, 8'h20); repeat (40) @(posedge aclk);
    wr(pcg_pkg::ADDR_LOOP_CTRL, 8'h00); rd(pcg_pkg::ADDR_BANDWIDTH);
    chk("loop off", rd_d[6:5], 2'b00);
    $display("register and lock test done");
    run <= 0; repeat (20) @(posedge aclk);
    results();
  end
endmodule
`default_nettype wire
